// ==== hw/dsi_seq_pkg.sv ====
// package for the panel timing sequencer: raster geometry, link timing, states
// assumes a single 50 MHz system clock drives every module that imports it
`default_nettype none
package dsi_seq_pkg;
  // system clock period, the base of every derived cycle count
  localparam int CLK_PERIOD_PS = 20000;
  // worst (longest) bit period the serialiser may use, for ui-based minima
  localparam int UI_MAX_PS = 12500;

  // least time in ps to whole cycles, rounded up, never below one cycle
  function automatic int ceil_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // clock lane entry and exit times, in their own units
  localparam int CLK_PREPARE_NS = 38;
  localparam int CLK_PREP_ZERO_NS = 300;
  localparam int CLK_TRAIL_NS = 60;
  localparam int HS_EXIT_NS = 100;
  localparam int CLK_POST_NS = 60;
  localparam int CLK_POST_UI = 52;
  localparam int CLK_PRE_UI = 8;

  // derived cycle counts, least times rounded up; zero is prepare-plus-zero less prepare
  localparam int CLK_PREPARE_CYC = ceil_cyc(CLK_PREPARE_NS * 1000);
  localparam int CLK_PREP_ZERO_CYC = ceil_cyc(CLK_PREP_ZERO_NS * 1000);
  localparam int CLK_ZERO_CYC = CLK_PREP_ZERO_CYC - CLK_PREPARE_CYC;
  localparam int CLK_TRAIL_CYC = ceil_cyc(CLK_TRAIL_NS * 1000);
  localparam int HS_EXIT_CYC = ceil_cyc(HS_EXIT_NS * 1000);
  localparam int CLK_POST_CYC = ceil_cyc(CLK_POST_NS * 1000 + CLK_POST_UI * UI_MAX_PS);
  localparam int CLK_PRE_CYC = ceil_cyc(CLK_PRE_UI * UI_MAX_PS);

  // lane timer width and typed load values
  localparam int LANE_TW = 8;
  localparam logic [LANE_TW-1:0] LD_PREPARE = LANE_TW'(CLK_PREPARE_CYC);
  localparam logic [LANE_TW-1:0] LD_ZERO = LANE_TW'(CLK_ZERO_CYC);
  localparam logic [LANE_TW-1:0] LD_TRAIL = LANE_TW'(CLK_TRAIL_CYC);
  localparam logic [LANE_TW-1:0] LD_EXIT = LANE_TW'(HS_EXIT_CYC);
  localparam logic [LANE_TW-1:0] LD_POST = LANE_TW'(CLK_POST_CYC);
  localparam logic [LANE_TW-1:0] LD_PRE = LANE_TW'(CLK_PRE_CYC);

  // power sequence times in ms, and cycles per ms
  localparam int CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
  localparam int RESET_LOW_MS = 10;
  localparam int POWER_TO_RESET_GAP_MS = 5;
  localparam int SLEEP_EXIT_MS = 120;
  localparam int MIN_UPTIME_MS = 200;
  localparam int RESET_LOW_DEF = RESET_LOW_MS * CYC_PER_MS;
  localparam int GAP_DEF = POWER_TO_RESET_GAP_MS * CYC_PER_MS;
  localparam int SLEEP_EXIT_DEF = SLEEP_EXIT_MS * CYC_PER_MS;
  localparam int MIN_UPTIME_DEF = MIN_UPTIME_MS * CYC_PER_MS;
  localparam int PW_TW = 24;

  // raster geometry in pixel clocks and lines
  localparam int RW = 11;
  localparam logic [RW-1:0] LINE_ACTIVE_PIXELS = 11'h320;
  localparam logic [RW-1:0] LINE_FRONT_PORCH = 11'h020;
  localparam logic [RW-1:0] LINE_SYNC_WIDTH = 11'h014;
  localparam logic [RW-1:0] LINE_BACK_PORCH = 11'h014;
  localparam logic [RW-1:0] FRAME_ACTIVE_LINES = 11'h500;
  localparam logic [RW-1:0] FRAME_FRONT_PORCH = 11'h010;
  localparam logic [RW-1:0] FRAME_SYNC_WIDTH = 11'h003;
  localparam logic [RW-1:0] FRAME_BACK_PORCH = 11'h00c;
  localparam logic [RW-1:0] H_SYNC_BEGIN = LINE_ACTIVE_PIXELS + LINE_FRONT_PORCH;
  localparam logic [RW-1:0] H_SYNC_END = H_SYNC_BEGIN + LINE_SYNC_WIDTH;
  localparam logic [RW-1:0] H_TOTAL = H_SYNC_END + LINE_BACK_PORCH;
  localparam logic [RW-1:0] V_SYNC_BEGIN = FRAME_ACTIVE_LINES + FRAME_FRONT_PORCH;
  localparam logic [RW-1:0] V_SYNC_END = V_SYNC_BEGIN + FRAME_SYNC_WIDTH;
  localparam logic [RW-1:0] V_TOTAL = V_SYNC_END + FRAME_BACK_PORCH;
  // 872 x 1311 x 60 stays under the 69 MHz pixel clock limit
  localparam longint FRAME_HZ = 60;
  localparam longint PIXEL_LIMIT_HZ = 69000000;
  localparam bit RATE_OK = (longint'(H_TOTAL) * longint'(V_TOTAL) * FRAME_HZ)
                           < PIXEL_LIMIT_HZ;

  // power sequencer states, gray along the power-on path
  typedef enum logic [2:0] {
    PW_OFF = 3'h0,
    PW_RST_LOW = 3'h1,
    PW_GAP = 3'h3,
    PW_SLEEP = 3'h2,
    PW_ON = 3'h6
  } pw_state_type;

  // clock lane states, gray around the burst loop
  typedef enum logic [2:0] {
    LN_IDLE = 3'h0,
    LN_PREP = 3'h1,
    LN_ZERO = 3'h3,
    LN_PRE = 3'h2,
    LN_RUN = 3'h6,
    LN_POST = 3'h7,
    LN_TRAIL = 3'h5,
    LN_EXIT = 3'h4
  } lane_state_type;
endpackage
`default_nettype wire

// ==== hw/dsi_interval_timer.sv ====
// loadable down-counter; done while the count sits at zero
// assumes load and value come from logic on the same clock
`default_nettype none
module dsi_interval_timer
  import dsi_seq_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // load request
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // status
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] count; // cycles still to run
  } tmr_type;

  tmr_type q;
  tmr_type next_q;

  // a loaded value n keeps done low for n cycles, so intervals never shrink
  always_comb begin
    next_q = q;
    if (load_i) begin
      next_q.count = value_i;
    end else if (q.count != '0) begin
      next_q.count = q.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done_o = (q.count == '0);
endmodule
`default_nettype wire

// ==== hw/dsi_raster_timing.sv ====
// raster generator: line and frame counters, sync and data-enable strobes
// assumes one pixel per clock while enable is high; restarts at frame top
`default_nettype none
module dsi_raster_timing
  import dsi_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic enable_i,
  // raster strobes
  output logic hsync_o,
  output logic vsync_o,
  output logic de_o,
  output logic frame_start_o
);
  typedef struct packed {
    logic [RW-1:0] h; // pixel within the line
    logic [RW-1:0] v; // line within the frame
    logic hs;
    logic vs;
    logic de;
    logic fs;
  } rast_type;

  rast_type q;
  rast_type next_q;

  // strobes decoded from the next counters so they line up with them
  always_comb begin
    next_q = q;
    if (!enable_i) begin
      // park on the last pixel so the first enabled clock shows pixel 0 of line 0
      next_q = '0;
      next_q.h = H_TOTAL - 1'b1;
      next_q.v = V_TOTAL - 1'b1;
    end else begin
      if (q.h == H_TOTAL - 1'b1) begin
        next_q.h = '0;
        next_q.v = (q.v == V_TOTAL - 1'b1) ? '0 : q.v + 1'b1;
      end else begin
        next_q.h = q.h + 1'b1;
      end
      next_q.de = (next_q.h < LINE_ACTIVE_PIXELS) && (next_q.v < FRAME_ACTIVE_LINES);
      next_q.hs = (next_q.h >= H_SYNC_BEGIN) && (next_q.h < H_SYNC_END);
      next_q.vs = (next_q.v >= V_SYNC_BEGIN) && (next_q.v < V_SYNC_END);
      next_q.fs = (next_q.h == '0) && (next_q.v == '0);
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hsync_o = q.hs;
  assign vsync_o = q.vs;
  assign de_o = q.de;
  assign frame_start_o = q.fs;

  // a raster cut by power-off may drop sync early, so only running lines count
  chk_hsync_place: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(hsync_o) && enable_i |-> (q.h == H_SYNC_END) && $past(q.h, 20) == H_SYNC_BEGIN)
    else $error("line sync not at its place or width");
  chk_vsync_place: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(vsync_o) |-> (q.v == V_SYNC_BEGIN) && (q.h == '0))
    else $error("frame sync not at its line");
endmodule
`default_nettype wire

// ==== hw/dsi_panel_timing_sequencer.sv ====
// host-side panel sequencer: power-on order, clock lane hs entry and exit, raster
// assumes request inputs come from logic on clk_i; pins drive a d-phy front end
`default_nettype none
module dsi_panel_timing_sequencer
  import dsi_seq_pkg::*;
#(
  parameter int RESET_LOW_CYC = RESET_LOW_DEF,
  parameter int GAP_CYC = GAP_DEF,
  parameter int SLEEP_EXIT_CYC = SLEEP_EXIT_DEF,
  parameter int MIN_UPTIME_CYC = MIN_UPTIME_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // power requests from the system
  input wire logic power_on_req_i,
  input wire logic power_off_req_i,
  // data lane handshake
  input wire logic data_hs_req_i,
  input wire logic data_lp_i,
  // panel power and control pins
  output logic logic_supply_en_o,
  output logic panel_reset_n_o,
  output logic link_enable_o,
  output logic sleep_exit_cmd_o,
  output logic power_ready_o,
  // clock lane drive
  output logic lp_dp_o,
  output logic lp_dn_o,
  output logic hs_drive_o,
  output logic clk_run_o,
  output logic data_hs_go_o,
  // raster strobes
  output logic hsync_o,
  output logic vsync_o,
  output logic de_o,
  output logic frame_start_o
);
  typedef struct packed {
    pw_state_type pw; // power sequence phase
    lane_state_type ln; // clock lane phase
    logic [PW_TW-1:0] uptime; // cycles since supply on, saturating
    logic [PW_TW-1:0] since; // cycles in the current power phase
    logic [LANE_TW-1:0] zcnt; // cycles of prepare plus zero so far
    logic supply;
    logic rst_n;
    logic link;
    logic slp_cmd;
    logic ready;
    logic dp;
    logic dn;
    logic hs;
    logic run;
    logic go;
  } core_type;

  core_type q;
  core_type next_q;
  logic pw_load; // restart the power timer
  logic [PW_TW-1:0] pw_val;
  logic pw_done;
  logic ln_load; // restart the lane timer
  logic [LANE_TW-1:0] ln_val;
  logic ln_done;

  // power timer: the long millisecond waits
  dsi_interval_timer #(.W(PW_TW)) pw_tmr (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(pw_load),
    .value_i(pw_val),
    .done_o(pw_done)
  );

  // lane timer: the nanosecond entry and exit waits
  dsi_interval_timer #(.W(LANE_TW)) ln_tmr (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(ln_load),
    .value_i(ln_val),
    .done_o(ln_done)
  );

  // raster only runs once the panel is out of sleep
  dsi_raster_timing raster (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .enable_i(q.ready),
    .hsync_o(hsync_o),
    .vsync_o(vsync_o),
    .de_o(de_o),
    .frame_start_o(frame_start_o)
  );

  // next state for both sequencers
  always_comb begin
    next_q = q;
    next_q.slp_cmd = 1'b0; // command is a single-cycle request
    pw_load = 1'b0;
    pw_val = '0;
    ln_load = 1'b0;
    ln_val = '0;

    // power sequence
    case (q.pw)
      PW_OFF: begin
        if (power_on_req_i) begin
          next_q.pw = PW_RST_LOW;
          next_q.supply = 1'b1;
          next_q.rst_n = 1'b0;
          pw_load = 1'b1;
          pw_val = PW_TW'(RESET_LOW_CYC);
        end
      end
      PW_RST_LOW: begin
        if (pw_done) begin
          next_q.pw = PW_GAP;
          next_q.rst_n = 1'b1;
          // link comes up at once, well inside the gap
          next_q.link = 1'b1;
          pw_load = 1'b1;
          pw_val = PW_TW'(GAP_CYC);
        end
      end
      PW_GAP: begin
        if (pw_done) begin
          next_q.pw = PW_SLEEP;
          next_q.slp_cmd = 1'b1;
          pw_load = 1'b1;
          pw_val = PW_TW'(SLEEP_EXIT_CYC);
        end
      end
      PW_SLEEP: begin
        if (pw_done) begin
          next_q.pw = PW_ON;
          next_q.ready = 1'b1;
        end
      end
      PW_ON: begin
        // a burst is never cut; removal waits for an idle lane and the uptime
        if (power_off_req_i && (q.ln == LN_IDLE) &&
            (q.uptime >= PW_TW'(MIN_UPTIME_CYC))) begin
          next_q.pw = PW_OFF;
          next_q.supply = 1'b0;
          next_q.rst_n = 1'b0;
          next_q.link = 1'b0;
          next_q.ready = 1'b0;
        end
      end
      default: begin
        next_q.pw = PW_OFF;
        next_q.supply = 1'b0;
        next_q.rst_n = 1'b0;
        next_q.link = 1'b0;
        next_q.ready = 1'b0;
      end
    endcase

    // uptime and phase counters, both saturating
    if (!q.supply) begin
      next_q.uptime = '0;
    end else if (q.uptime != '1) begin
      next_q.uptime = q.uptime + 1'b1;
    end
    if (next_q.pw != q.pw) begin
      next_q.since = '0;
    end else if (q.since != '1) begin
      next_q.since = q.since + 1'b1;
    end

    // clock lane
    case (q.ln)
      LN_IDLE: begin
        next_q.dp = 1'b1;
        next_q.dn = 1'b1;
        next_q.zcnt = '0;
        // lane timer has already run out the exit time of the last burst before idle
        if (q.link && data_hs_req_i && ln_done) begin
          next_q.ln = LN_PREP;
          next_q.dp = 1'b0;
          next_q.dn = 1'b0;
          ln_load = 1'b1;
          ln_val = LD_PREPARE;
        end
      end
      LN_PREP: begin
        if (ln_done) begin
          next_q.ln = LN_ZERO;
          next_q.hs = 1'b1;
          ln_load = 1'b1;
          ln_val = LD_ZERO;
        end
      end
      LN_ZERO: begin
        if (ln_done) begin
          next_q.ln = LN_PRE;
          next_q.run = 1'b1;
          ln_load = 1'b1;
          ln_val = LD_PRE;
        end
      end
      LN_PRE: begin
        if (ln_done) begin
          next_q.ln = LN_RUN;
          next_q.go = 1'b1;
        end
      end
      LN_RUN: begin
        // end of burst only once the data lanes are back in low power
        if (!data_hs_req_i && data_lp_i) begin
          next_q.ln = LN_POST;
          next_q.go = 1'b0;
          ln_load = 1'b1;
          ln_val = LD_POST;
        end
      end
      LN_POST: begin
        if (ln_done) begin
          next_q.ln = LN_TRAIL;
          next_q.run = 1'b0;
          ln_load = 1'b1;
          ln_val = LD_TRAIL;
        end
      end
      LN_TRAIL: begin
        if (ln_done) begin
          next_q.ln = LN_EXIT;
          next_q.hs = 1'b0;
          next_q.dp = 1'b1;
          next_q.dn = 1'b1;
          ln_load = 1'b1;
          ln_val = LD_EXIT;
        end
      end
      LN_EXIT: begin
        if (ln_done) begin
          next_q.ln = LN_IDLE;
        end
      end
      default: begin
        next_q.ln = LN_IDLE;
      end
    endcase

    // helper count of prepare plus zero, read by the lane checks
    if ((q.ln == LN_PREP || q.ln == LN_ZERO) && (q.zcnt != '1)) begin
      next_q.zcnt = q.zcnt + 1'b1;
    end

    // without the link every lane line is held low
    if (!next_q.link) begin
      next_q.ln = LN_IDLE;
      next_q.dp = 1'b0;
      next_q.dn = 1'b0;
      next_q.hs = 1'b0;
      next_q.run = 1'b0;
      next_q.go = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // all control outputs straight from flops
  assign logic_supply_en_o = q.supply;
  assign panel_reset_n_o = q.rst_n;
  assign link_enable_o = q.link;
  assign sleep_exit_cmd_o = q.slp_cmd;
  assign power_ready_o = q.ready;
  assign lp_dp_o = q.dp;
  assign lp_dn_o = q.dn;
  assign hs_drive_o = q.hs;
  assign clk_run_o = q.run;
  assign data_hs_go_o = q.go;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  chk_prepare_hold: assert property ($rose(hs_drive_o) |->
    $past(!lp_dp_o && !lp_dn_o, 1) && $past(!lp_dp_o && !lp_dn_o, 2))
    else $error("lp-00 too short before hs-0");
  chk_zero_total: assert property ($rose(clk_run_o) |->
    $past(q.zcnt) >= LANE_TW'(CLK_PREP_ZERO_CYC))
    else $error("prepare plus zero too short");
  chk_pre_clock: assert property ($rose(data_hs_go_o) |->
    clk_run_o && $past(clk_run_o, 5))
    else $error("data entered hs before clock ran long enough");
  chk_post_clock: assert property ($fell(clk_run_o) |->
    $past(clk_run_o, 36) && !$past(data_hs_go_o, 36))
    else $error("clock stopped too soon after data");
  chk_trail_hold: assert property ($fell(clk_run_o) |-> hs_drive_o [*3])
    else $error("hs-0 trail too short");
  chk_exit_hold: assert property ($fell(hs_drive_o) && link_enable_o |->
    (lp_dp_o && lp_dn_o && !hs_drive_o) [*5])
    else $error("lp-11 exit too short");
  chk_supply_quiet: assert property (!logic_supply_en_o |->
    !panel_reset_n_o && !link_enable_o && !lp_dp_o && !lp_dn_o && !hs_drive_o)
    else $error("signal driven while supply off");
  chk_reset_low: assert property ($rose(panel_reset_n_o) |->
    $past(q.since) >= PW_TW'(RESET_LOW_CYC) && logic_supply_en_o)
    else $error("reset released too early");
  chk_sleep_wait: assert property ($rose(power_ready_o) |->
    $past(q.since) >= PW_TW'(SLEEP_EXIT_CYC))
    else $error("ready before sleep-exit wait");
  chk_link_first: assert property (sleep_exit_cmd_o |->
    link_enable_o && panel_reset_n_o && $past(q.since) >= PW_TW'(GAP_CYC))
    else $error("sleep-exit without link or gap");
  chk_min_uptime: assert property ($fell(logic_supply_en_o) |->
    $past(q.uptime) >= PW_TW'(MIN_UPTIME_CYC))
    else $error("supply removed too soon");
endmodule
`default_nettype wire

// ==== dv/panel_model.sv ====
// panel model: clock lane receiver termination and supply-off pin watch
// assumes host pins are sampled on the bench clock, one cycle being 20 ns
`default_nettype none
module panel_model (
  // clock
  input wire logic clk_i,
  // host pins
  input wire logic supply_i,
  input wire logic pins_i,
  input wire logic lp_dp_i,
  input wire logic lp_dn_i,
  input wire logic hs_i,
  input wire logic clk_run_i,
  // model status
  output logic term_en_o,
  output logic off_fault_o,
  output var int bursts_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic term = 1'b0; // hs line termination on
  logic lp11_q = 1'b0; // lane sat in lp-11 last cycle
  logic run_q = 1'b0; // last clock-run level
  logic fault = 1'b0; // sticky: a pin high while unpowered
  int cnt = 0; // bursts clocked into a terminated lane
  // termination one cycle (20 ns) after lp-11 to lp-00, dropped at lp-11
  always @(posedge clk_i) begin
    lp11_q <= lp_dp_i & lp_dn_i;
    run_q <= clk_run_i;
    if (lp_dp_i & lp_dn_i) term <= 1'b0;
    else if (lp11_q) term <= 1'b1;
    // a clock started before termination would be lost on real glass
    if (clk_run_i && !run_q && term && hs_i) cnt <= cnt + 1;
    if (!supply_i && (pins_i || lp_dp_i || lp_dn_i || hs_i || clk_run_i)) fault <= 1'b1;
  end
  assign term_en_o = term;
  assign off_fault_o = fault;
  assign bursts_o = cnt;
endmodule
`default_nettype wire

// ==== dv/dsi_panel_timing_sequencer_tb.sv ====
// bench for the panel sequencer: power order, clock lane bursts, raster lines
// assumes the panel model on the far side and shortened power counts
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module dsi_panel_timing_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int R = 20; // shortened counts, cycles
  localparam int G = 10;
  localparam int S = 30;
  localparam int U = 100;
  typedef struct {logic v; int lo; int hi;} note_type;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic on_req = 1'b0, off_req = 1'b0, hs_req = 1'b0, data_lp = 1'b1;
  logic supply_en, reset_n, link_en, sleep_cmd, ready, lp_dp, lp_dn, hs_drive;
  logic clk_run, hs_go, hsync, vsync, de, frame_start, term_en, off_fault;
  int bursts;
  int cyc = 0, num_errors = 0, n_checks = 0, free_at = 0, nb = 0;
  int ev_t [24]; // cycle of last change, per output and level
  note_type nq [12][$]; // expected changes, one queue per output
  note_type nt;
  logic [11:0] cur, prev;
  logic [31:0] seed = 32'h588fee9c;
  bit raster_on = 1'b0; // raster outputs only watched while set

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  dsi_panel_timing_sequencer #(.RESET_LOW_CYC(R), .GAP_CYC(G), .SLEEP_EXIT_CYC(S),
    .MIN_UPTIME_CYC(U)) uut (.clk_i(clk_i), .srst_i(srst_i), .power_on_req_i(on_req),
    .power_off_req_i(off_req), .data_hs_req_i(hs_req), .data_lp_i(data_lp),
    .logic_supply_en_o(supply_en), .panel_reset_n_o(reset_n), .link_enable_o(link_en),
    .sleep_exit_cmd_o(sleep_cmd), .power_ready_o(ready), .lp_dp_o(lp_dp), .lp_dn_o(lp_dn),
    .hs_drive_o(hs_drive), .clk_run_o(clk_run), .data_hs_go_o(hs_go), .hsync_o(hsync),
    .vsync_o(vsync), .de_o(de), .frame_start_o(frame_start));

  panel_model panel (.clk_i(clk_i), .supply_i(supply_en), .pins_i(reset_n | link_en),
    .lp_dp_i(lp_dp), .lp_dn_i(lp_dn), .hs_i(hs_drive), .clk_run_i(clk_run),
    .term_en_o(term_en), .off_fault_o(off_fault), .bursts_o(bursts));

  // watcher: each output change takes the oldest note of that output
  always @(negedge clk_i) begin
    cur = {frame_start, de, hsync, hs_go, clk_run, hs_drive, lp_dp, ready, sleep_cmd,
           link_en, reset_n, supply_en};
    if (!srst_i) begin
      `CHK(lp_dn, lp_dp, "lp lines split")
      for (int i = 0; i < 12; i++) begin
        if (cur[i] !== prev[i] && (i < 9 || raster_on)) begin
          if (nq[i].size() == 0) begin
            num_errors++;
            $display("CHECK FAILED t=%0t output %0d moved unasked", $time, i);
          end else begin
            nt = nq[i].pop_front();
            `CHK(cur[i], nt.v, "level")
            `CHK(cyc >= nt.lo && cyc <= nt.hi, 1'b1, "timing")
          end
          ev_t[i * 2 + int'(cur[i])] = cyc;
        end
      end
    end
    prev = cur;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic note(input int i, input logic v, input int lo, input int hi);
    note_type n;
    n.v = v;
    n.lo = lo;
    n.hi = hi;
    nq[i].push_back(n);
  endtask

  // bounded wait for a change noted at or after cycle since
  task automatic wait_ev(input int code, input int since, output int t);
    int k;
    for (k = 0; k < 5000 && ev_t[code] < since; k++) @(posedge clk_i);
    t = ev_t[code];
    if (t < since) begin
      num_errors++;
      $display("CHECK FAILED t=%0t no change %0d", $time, code);
      test_done();
    end
  endtask

  // power-off: supply, reset, link, ready and lp lines all drop together
  task automatic off_notes(input int lo, input int hi);
    note(0, 1'b0, lo, hi);
    note(1, 1'b0, lo, hi);
    note(2, 1'b0, lo, hi);
    note(4, 1'b0, lo, hi);
    note(5, 1'b0, lo, hi);
  endtask

  task automatic power_up(input bit ras, output int ts);
    int t0, tr, tp, ty, f, b;
    @(negedge clk_i);
    // the edge that samples the request is counted as t0 + 1
    t0 = cyc;
    on_req = 1'b1;
    note(0, 1'b1, t0 + 1, t0 + 1);
    note(1, 1'b1, t0 + R + 2, t0 + R + 3);
    note(2, 1'b1, t0 + R + 2, t0 + R + 3);
    note(5, 1'b1, t0 + R + 2, t0 + R + 4);
    wait_ev(1, t0, ts);
    @(negedge clk_i);
    on_req = 1'b0;
    wait_ev(3, t0, tr);
    note(3, 1'b1, tr + G + 1, tr + G + 1);
    note(3, 1'b0, tr + G + 2, tr + G + 2);
    wait_ev(7, tr, tp);
    note(4, 1'b1, tp + S + 1, tp + S + 1);
    if (ras) begin
      note(11, 1'b1, tp + S + 2, tp + S + 3);
      note(10, 1'b1, tp + S + 2, tp + S + 3);
      raster_on = 1'b1;
    end
    wait_ev(9, tp, ty);
    if (ras) begin
      wait_ev(23, ty, f);
      note(11, 1'b0, f + 1, f + 1);
      for (int l = 0; l < 2; l++) begin
        b = f + l * 872;
        note(10, 1'b0, b + 800, b + 800);
        note(9, 1'b1, b + 832, b + 832);
        note(9, 1'b0, b + 852, b + 852);
        note(10, 1'b1, b + 872, b + 872);
      end
      while (cyc < f + 1746) @(posedge clk_i);
      `CHK(vsync, 1'b0, "frame sync inside active lines")
      raster_on = 1'b0;
    end
  endtask

  // one clock lane burst; a request inside the exit wait is held, not lost
  task automatic burst(input int hold, input bit off);
    int t0, tg, e;
    @(negedge clk_i);
    t0 = (cyc > free_at) ? cyc : free_at;
    hs_req = 1'b1;
    note(5, 1'b0, t0 + 1, t0 + 1);
    note(6, 1'b1, t0 + 4, t0 + 4);
    note(7, 1'b1, t0 + 18, t0 + 18);
    note(8, 1'b1, t0 + 24, t0 + 24);
    wait_ev(17, t0, tg);
    @(negedge clk_i);
    data_lp = 1'b0;
    off_req = off;
    repeat (hold) @(negedge clk_i);
    hs_req = 1'b0;
    data_lp = 1'b1;
    e = cyc;
    note(8, 1'b0, e + 1, e + 1);
    note(7, 1'b0, e + 38, e + 38);
    note(6, 1'b0, e + 42, e + 42);
    note(5, 1'b1, e + 42, e + 42);
    free_at = e + 48;
    nb++;
    if (off) begin
      off_notes(e + 43, e + 49);
      wait_ev(0, e, tg);
      @(negedge clk_i);
      off_req = 1'b0;
    end
  endtask

  initial begin
    int ts, t;
    for (int i = 0; i < 24; i++) ev_t[i] = -1;
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    power_up(1'b1, ts);
    $display("power-on order and raster lines done");
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      burst(1 + int'(seed[3:0]), 1'b0);
      repeat (seed[9:5]) @(negedge clk_i);
    end
    $display("random bursts done");
    burst(5, 1'b1);
    $display("power-off held behind a burst done");
    power_up(1'b0, ts);
    @(negedge clk_i);
    off_req = 1'b1;
    off_notes(ts + U, ts + U + 2);
    wait_ev(0, ts, t);
    @(negedge clk_i);
    off_req = 1'b0;
    $display("early power-off held to uptime done");
    repeat (60) @(negedge clk_i);
    for (int i = 0; i < 12; i++) `CHK(nq[i].size(), 0, "expected change missing")
    `CHK(bursts, nb, "panel burst count")
    `CHK(off_fault, 1'b0, "pin high while supply off")
    test_done();
  end
endmodule
`default_nettype wire
